// >>> design/angle_readout_regs.svh
// command codes, field positions, reset values and timing counts of the angle readout
`ifndef ANGLE_READOUT_REGS_SVH
`define ANGLE_READOUT_REGS_SVH

// ************************************************************
// command codes (5 bits, msb first on the wire)
// ************************************************************
`define CMD_ANGLE_FETCH      5'h00
`define CMD_TURNS_FETCH      5'h01
`define CMD_SINE_FETCH       5'h02
`define CMD_STORE_REF        5'h03
`define CMD_BOTH_FETCH       5'h04
`define CMD_COSINE_FETCH     5'h06
`define CMD_CUST_FETCH       5'h07
`define CMD_SLEEP_LOAD       5'h11
`define CMD_SINE_LOAD        5'h12
`define CMD_HYST_LOAD        5'h13
`define CMD_RESERVED         5'h14
`define CMD_TEST_LOAD        5'h15
`define CMD_COSINE_LOAD      5'h16
`define CMD_CUST_LOAD        5'h17

// ************************************************************
// frame layout
// ************************************************************
`define CMD_BITS             5'h05
`define FRAME_BITS           5'h15
`define CMD_WRITE_BIT        4

// ************************************************************
// field positions
// ************************************************************
`define CUST_WAKE_MSB        14
`define CUST_WAKE_LSB        8
`define CUST_GAIN_MSB        7
`define CUST_GAIN_LSB        5
`define HYST_FUSE_BIT        15
`define HYST_TURN_CLR_BIT    13
`define HYST_ENABLE_BIT      11
`define TEST_RESET_BIT       14
`define SLEEP_BIT            15
`define STORE_OK_BIT         15

// ************************************************************
// reset values and limits
// ************************************************************
`define WAKE_RESET           7'h04
`define WAKE_MIN             7'h04
`define GAIN_RESET           3'h0
`define ARRAY_RESET          16'h0000
`define HYST_RESET           1'h1

// ************************************************************
// timing
// ************************************************************
`define MCLK_KHZ             10000
`define PWM_LSB_PS           556000
`define PWM_LSB_CYC          ((`PWM_LSB_PS / 1000 * `MCLK_KHZ / 1000 + 999) / 1000)
`define PWM_LAST_SLOT        9'h100

`endif

// >>> design/angle_readout_pkg.sv
// types shared by the angle readout design
package angle_readout_pkg;
  typedef logic [4:0]  cmd_t;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  angle_t;
  typedef logic [5:0]  agc_t;
  typedef logic [6:0]  wake_t;
  typedef logic [2:0]  gain_t;
endpackage

// >>> design/angle_serial_pwm_readout.sv
// serial command interface and pwm output of the rotary angle sensor readout
// Operation
// - serial traffic uses one data pin, framed, clocked
// - five command bits then sixteen data bits
// - combined read returns turns high, angle low
// - store command latches reference, returns supply flag
// - settings read returns wake threshold and gain
// - settings write loads wake threshold and gain
// - array writes set exclude and invert per element
// - array reads return same exclude/invert layout
// - test write takes digital reset in bit 14
// - hysteresis write: fuse reload, turn clear, enable
// - sleep write bit 15 enters/leaves low power
// - invalid angle holds pwm low
// - pwm high time is position plus one
// - pwm period always 257 lsb
// - one pwm lsb is nominally 0.556 us
// - angle and turn reads carry even parity
// - hysteresis needs two equal samples to change
// - wake threshold defaults 4, below 4 refused
// - digital reset bit resets the logic
`timescale 1ns/10ps
`include "angle_readout_regs.svh"

module angle_serial_pwm_readout
(
  // system clock and control
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic                     clk_en,
  // serial link from the controller
  input  wire logic                     sclk,
  input  wire logic                     chip_sel,
  input  wire logic                     serial_data_pin_i,
  output logic                          serial_data_pin_o,
  output logic                          serial_data_pin_oe,
  // measurement path
  input  wire angle_readout_pkg::angle_t angle_sample,
  input  wire logic                     sample_strobe,
  input  wire logic                     angle_invalid,
  input  wire angle_readout_pkg::agc_t   agc_level,
  input  wire logic                     adc_lock,
  input  wire logic                     store_supply_ok,
  // settings and status toward the analog side
  output angle_readout_pkg::wake_t      wake_threshold,
  output angle_readout_pkg::gain_t      gain_setting,
  output angle_readout_pkg::word_t      cosine_array_setup,
  output angle_readout_pkg::word_t      sine_array_setup,
  output logic                          hysteresis_enable,
  output logic                          sleep_request,
  output logic                          fuse_reload,
  output angle_readout_pkg::angle_t     turn_count,
  // pwm output
  output logic                          pwm_out
);
  import angle_readout_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  logic        rst;
  logic        soft_rst_q;
  logic        link_rst_q;
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic        tgl_s1_q;
  logic        tgl_s2_q;
  logic        tgl_seen_q;
  // link domain
  logic [4:0]  bit_cnt_q;
  cmd_t        cmd_sr_q;
  word_t       data_sr_q;
  word_t       rd_sr_q;
  logic        is_read_q;
  cmd_t        frame_cmd_q;
  word_t       frame_data_q;
  logic        frame_tgl_q;
  logic        dout_q;
  logic        oe_q;
  // mclk domain state
  wake_t       wake_q;
  gain_t       gain_q;
  word_t       cos_q;
  word_t       sin_q;
  logic        hyst_en_q;
  logic        sleep_q;
  logic        fuse_q;
  angle_t      angle_q;
  angle_t      smp_prev_q;
  angle_t      turns_q;
  angle_t      ref_angle_q;
  logic        store_ok_q;
  // read shadows, frozen while a frame runs
  word_t       sh_angle_q;
  word_t       sh_turns_q;
  word_t       sh_both_q;
  word_t       sh_store_q;
  word_t       sh_cust_q;
  word_t       sh_cos_q;
  word_t       sh_sin_q;
  // pwm
  logic [2:0]  presc_q;
  logic [8:0]  slot_q;
  angle_t      duty_q;
  logic        pwm_q;

  // ************************************************************
  // frame decode in the mclk domain
  // ************************************************************
  wire         frame_ev    = tgl_s2_q != tgl_seen_q;
  wire         wr_cust     = frame_ev && frame_cmd_q == `CMD_CUST_LOAD;
  wire         wr_cos      = frame_ev && frame_cmd_q == `CMD_COSINE_LOAD;
  wire         wr_sin      = frame_ev && frame_cmd_q == `CMD_SINE_LOAD;
  wire         wr_test     = frame_ev && frame_cmd_q == `CMD_TEST_LOAD;
  wire         wr_hyst     = frame_ev && frame_cmd_q == `CMD_HYST_LOAD;
  wire         wr_sleep    = frame_ev && frame_cmd_q == `CMD_SLEEP_LOAD;
  wire         do_store    = frame_ev && frame_cmd_q == `CMD_STORE_REF;
  wire wake_t  wake_field  = frame_data_q[`CUST_WAKE_MSB:`CUST_WAKE_LSB];
  wire gain_t  gain_field  = frame_data_q[`CUST_GAIN_MSB:`CUST_GAIN_LSB];
  wire         wake_ok     = wake_field >= `WAKE_MIN;
  wire         turn_clr    = wr_hyst && frame_data_q[`HYST_TURN_CLR_BIT];
  wire         soft_rst_d  = wr_test && frame_data_q[`TEST_RESET_BIT];

  assign rst = srst || soft_rst_q;

  // ************************************************************
  // angle hysteresis and turn counting
  // ************************************************************
  wire         angle_upd   = sample_strobe && angle_sample != angle_q
                             && (!hyst_en_q || angle_sample == smp_prev_q);
  wire         wrap_fwd    = angle_q[7:6] == 2'h3 && angle_sample[7:6] == 2'h0;
  wire         wrap_back   = angle_q[7:6] == 2'h0 && angle_sample[7:6] == 2'h3;
  wire angle_t turn_step   = !angle_upd ? 8'h00 : wrap_fwd ? 8'h01 : wrap_back ? 8'hff : 8'h00;
  wire angle_t turns_base  = turn_clr ? 8'h00 : turns_q;
  wire angle_t turns_d     = turns_base + turn_step;

  // ************************************************************
  // read words
  // ************************************************************
  wire         lock_bit    = adc_lock && !sleep_q;
  wire [14:0]  angle_body  = {lock_bit, agc_level, angle_q};
  wire [14:0]  turns_body  = {lock_bit, agc_level, turns_q};
  wire [14:0]  store_body  = {store_ok_q, 6'h00, ref_angle_q};
  wire [14:0]  cust_body   = {wake_q, gain_q, 5'h00};
  wire word_t  angle_word  = {angle_body, ^angle_body};
  wire word_t  turns_word  = {turns_body, ^turns_body};
  wire word_t  store_word  = {store_body, ^store_body};
  wire word_t  cust_word   = {1'h0, cust_body[14:1], ^cust_body[14:1]};
  wire word_t  both_word   = {turns_q, angle_q};

  // ************************************************************
  // mclk domain: synchronisers and soft reset
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cs_s1_q    <= 1'h0;
      cs_s2_q    <= 1'h0;
      tgl_s1_q   <= 1'h0;
      tgl_s2_q   <= 1'h0;
      soft_rst_q <= 1'h0;
      link_rst_q <= 1'h1;
    end
    else if (clk_en)
    begin
      cs_s1_q    <= chip_sel;
      cs_s2_q    <= cs_s1_q;
      tgl_s1_q   <= frame_tgl_q;
      tgl_s2_q   <= tgl_s1_q;
      soft_rst_q <= soft_rst_d;
      link_rst_q <= 1'h0;
    end
  end

  // frame events already pending at reset are taken as seen
  always_ff @(posedge mclk)
  begin
    if (srst)
      tgl_seen_q <= tgl_s2_q;
    else if (clk_en)
      tgl_seen_q <= tgl_s2_q;
  end

  // ************************************************************
  // mclk domain: settings written over the link
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wake_q    <= `WAKE_RESET;
      gain_q    <= `GAIN_RESET;
      cos_q     <= `ARRAY_RESET;
      sin_q     <= `ARRAY_RESET;
      hyst_en_q <= `HYST_RESET;
      sleep_q   <= 1'h0;
      fuse_q    <= 1'h0;
    end
    else if (clk_en)
    begin
      if (wr_cust && wake_ok)
        wake_q <= wake_field;
      if (wr_cust)
        gain_q <= gain_field;
      if (wr_cos)
        cos_q <= frame_data_q;
      if (wr_sin)
        sin_q <= frame_data_q;
      if (wr_hyst)
        hyst_en_q <= frame_data_q[`HYST_ENABLE_BIT];
      if (wr_sleep)
        sleep_q <= frame_data_q[`SLEEP_BIT];
      fuse_q <= wr_hyst && frame_data_q[`HYST_FUSE_BIT];
    end
  end

  // ************************************************************
  // mclk domain: measurement state
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      angle_q     <= 8'h00;
      smp_prev_q  <= 8'h00;
      turns_q     <= 8'h00;
      ref_angle_q <= 8'h00;
      store_ok_q  <= 1'h0;
    end
    else if (clk_en)
    begin
      if (sample_strobe)
        smp_prev_q <= angle_sample;
      if (angle_upd)
        angle_q <= angle_sample;
      turns_q <= turns_d;
      if (do_store)
      begin
        ref_angle_q <= angle_q;
        store_ok_q  <= store_supply_ok;
      end
    end
  end

  // ************************************************************
  // mclk domain: read shadows, updated only between frames
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sh_angle_q <= 16'h0000;
      sh_turns_q <= 16'h0000;
      sh_both_q  <= 16'h0000;
      sh_store_q <= 16'h0000;
      sh_cust_q  <= 16'h0000;
      sh_cos_q   <= 16'h0000;
      sh_sin_q   <= 16'h0000;
    end
    else if (clk_en && !cs_s2_q)
    begin
      sh_angle_q <= angle_word;
      sh_turns_q <= turns_word;
      sh_both_q  <= both_word;
      sh_store_q <= store_word;
      sh_cust_q  <= cust_word;
      sh_cos_q   <= cos_q;
      sh_sin_q   <= sin_q;
    end
  end

  // ************************************************************
  // pwm generator
  // ************************************************************
  wire         lsb_tick    = presc_q == 3'(`PWM_LSB_CYC - 1);
  wire         slot_wrap   = slot_q == `PWM_LAST_SLOT;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      presc_q <= 3'h0;
      slot_q  <= 9'h000;
      duty_q  <= 8'h00;
      pwm_q   <= 1'h0;
    end
    else if (clk_en)
    begin
      presc_q <= lsb_tick ? 3'h0 : presc_q + 3'h1;
      if (lsb_tick)
        slot_q <= slot_wrap ? 9'h000 : slot_q + 9'h001;
      if (lsb_tick && slot_wrap)
        duty_q <= angle_q;
      pwm_q <= !angle_invalid && slot_q <= {1'h0, duty_q};
    end
  end

  // ************************************************************
  // link domain: command and data shift on rising sclk
  // ************************************************************
  wire cmd_t   cmd_full    = {cmd_sr_q[3:0], serial_data_pin_i};
  wire word_t  rd_sel      = cmd_full == `CMD_ANGLE_FETCH  ? sh_angle_q :
                             cmd_full == `CMD_TURNS_FETCH  ? sh_turns_q :
                             cmd_full == `CMD_BOTH_FETCH   ? sh_both_q  :
                             cmd_full == `CMD_STORE_REF    ? sh_store_q :
                             cmd_full == `CMD_CUST_FETCH   ? sh_cust_q  :
                             cmd_full == `CMD_COSINE_FETCH ? sh_cos_q   :
                             cmd_full == `CMD_SINE_FETCH   ? sh_sin_q   : 16'h0000;
  wire         in_cmd      = bit_cnt_q < `CMD_BITS;
  wire         last_cmd    = bit_cnt_q == `CMD_BITS - 5'h01;
  wire         last_data   = bit_cnt_q == `FRAME_BITS - 5'h01;

  // counters clear whenever chip select drops, so each frame starts fresh
  always_ff @(posedge sclk or negedge chip_sel)
  begin
    if (!chip_sel)
    begin
      bit_cnt_q <= 5'h00;
      cmd_sr_q  <= 5'h00;
      data_sr_q <= 16'h0000;
      rd_sr_q   <= 16'h0000;
      is_read_q <= 1'h0;
    end
    else
    begin
      if (bit_cnt_q < `FRAME_BITS)
        bit_cnt_q <= bit_cnt_q + 5'h01;
      if (in_cmd)
        cmd_sr_q <= cmd_full;
      else
        data_sr_q <= {data_sr_q[14:0], serial_data_pin_i};
      if (last_cmd)
      begin
        rd_sr_q   <= rd_sel;
        is_read_q <= !cmd_full[`CMD_WRITE_BIT];
      end
      else
        rd_sr_q <= {rd_sr_q[14:0], 1'h0};
    end
  end

  // completed frame handed to mclk by a toggle; words stay stable until the next frame ends
  always_ff @(posedge sclk or posedge link_rst_q)
  begin
    if (link_rst_q)
    begin
      frame_cmd_q  <= 5'h00;
      frame_data_q <= 16'h0000;
      frame_tgl_q  <= 1'h0;
    end
    else if (chip_sel && last_data)
    begin
      frame_cmd_q  <= cmd_sr_q;
      frame_data_q <= {data_sr_q[14:0], serial_data_pin_i};
      frame_tgl_q  <= !frame_tgl_q;
    end
  end

  // read data launched on falling sclk, half a bit after the last command bit
  always_ff @(negedge sclk or negedge chip_sel)
  begin
    if (!chip_sel)
    begin
      dout_q <= 1'h0;
      oe_q   <= 1'h0;
    end
    else
    begin
      dout_q <= rd_sr_q[15];
      oe_q   <= is_read_q && !in_cmd;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign serial_data_pin_o  = dout_q;
  assign serial_data_pin_oe = oe_q;
  assign wake_threshold     = wake_q;
  assign gain_setting       = gain_q;
  assign cosine_array_setup = cos_q;
  assign sine_array_setup   = sin_q;
  assign hysteresis_enable  = hyst_en_q;
  assign sleep_request      = sleep_q;
  assign fuse_reload        = fuse_q;
  assign turn_count         = turns_q;
  assign pwm_out            = pwm_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking mclk_cb @(posedge mclk iff clk_en);
  endclocking
  default disable iff (rst);

  AST_PWM_LOW_INVALID: assert property (angle_invalid |=> !pwm_q)
    else $error("pwm high while angle invalid");
  AST_PWM_HIGH: assert property (!angle_invalid && slot_q <= {1'h0, duty_q} |=> pwm_q)
    else $error("pwm low inside high time");
  AST_PWM_PERIOD: assert property (lsb_tick && slot_wrap |=> slot_q == 9'h000)
    else $error("pwm period not 257 slots");
  AST_PWM_LSB: assert property (lsb_tick |=> (!lsb_tick) [*5] ##1 lsb_tick)
    else $error("pwm lsb length wrong");
  AST_WAKE_MIN: assert property (wake_q >= `WAKE_MIN)
    else $error("wake threshold below minimum");
  AST_CUST_LOAD: assert property (wr_cust && wake_ok |=> wake_q == $past(wake_field)
                                  && gain_q == $past(gain_field))
    else $error("settings write not loaded");
  AST_TURN_CLR: assert property (turn_clr && turn_step == 8'h00 |=> turns_q == 8'h00)
    else $error("turn count not cleared");
  AST_HYST: assert property (hyst_en_q && sample_strobe && angle_sample != smp_prev_q
                             |=> angle_q == $past(angle_q))
    else $error("angle changed on a single sample");
  AST_SLEEP: assert property (wr_sleep |=> sleep_q == $past(frame_data_q[`SLEEP_BIT]))
    else $error("sleep request not taken");
  AST_PARITY: assert property (^angle_word == 1'h0 && ^turns_word == 1'h0)
    else $error("read word parity odd");
  AST_SOFT_RST: assert property (@(posedge mclk iff clk_en) disable iff (srst)
                                 soft_rst_d |=> soft_rst_q ##1 wake_q == `WAKE_RESET)
    else $error("digital reset did not act");
  AST_DRIVE_READ: assert property (@(negedge sclk) disable iff (!chip_sel)
                                   oe_q |-> is_read_q && bit_cnt_q >= `CMD_BITS)
    else $error("data pin driven outside read data phase");

  COV_PWM_WRAP: cover property (lsb_tick && slot_wrap && !angle_invalid);
  COV_CUST_WRITE: cover property (wr_cust && wake_ok);
  COV_READ_DRIVE: cover property (@(negedge sclk) disable iff (!chip_sel) oe_q && bit_cnt_q == `FRAME_BITS);
  COV_HYST_UPDATE: cover property (hyst_en_q && angle_upd);
endmodule

// >>> dv/serial_master_model.sv
// controller-side model: chip select, link clock and the shared data pin
`timescale 1ns/10ps

module serial_master_model
(
  // link toward the device
  output logic      sclk,
  output logic      chip_sel,
  output logic      data_to_dev,
  // device side of the data pin
  input  wire logic dev_o,
  input  wire logic dev_oe
);
  logic m_oe;
  logic m_d;
  logic float_q;

  initial
  begin
    sclk = 1'b0;
    chip_sel = 1'b1;
    m_oe = 1'b0;
    m_d = 1'b0;
    float_q = 1'b0;
    // a falling select at start clears the link counters and shift registers, which have no other reset
    #1;
    chip_sel = 1'b0;
  end

  // an undriven pin has no pull, so it toggles on every link edge
  always @(sclk)
    float_q = ~float_q;

  assign data_to_dev = dev_oe ? dev_o : (m_oe ? m_d : float_q);

  // ************************************************************
  // one whole frame: 5 command bits, 16 data bits
  // ************************************************************
  task automatic frame(input logic [4:0] cmd, input logic [15:0] wdata, output logic [15:0] rdata);
    logic [20:0] bits;
    bits = {cmd, wdata};
    rdata = 16'h0000;
    #13;
    chip_sel = 1'b1;
    #400;
    for (int i = 20; i >= 0; i--)
    begin
      m_oe = cmd[4] || (i > 15);
      m_d = bits[i];
      #62.5;
      sclk = 1'b1;
      if (!cmd[4] && i <= 15)
        rdata[i] = data_to_dev;
      #62.5;
      sclk = 1'b0;
    end
    m_oe = 1'b0;
    #100;
    chip_sel = 1'b0;
    #1000;
  endtask
endmodule

// >>> dv/angle_serial_pwm_readout_bench.sv
// self-checking bench for the serial command link and pwm output
`timescale 1ns/10ps
`include "angle_readout_regs.svh"

module angle_serial_pwm_readout_bench;
  import angle_readout_pkg::*;
  logic   mclk, srst, clk_en, sclk, chip_sel, pin_level, dev_o, dev_oe;
  logic   sample_strobe, angle_invalid, adc_lock, store_supply_ok;
  logic   hysteresis_enable, sleep_request, fuse_reload, pwm_out;
  angle_t angle_sample, turn_count;
  agc_t   agc_level;
  wake_t  wake_threshold;
  gain_t  gain_setting;
  word_t  cosine_array_setup, sine_array_setup, rx;
  int     mismatches, n_compared, fuse_n, hi, lo, n;

  angle_serial_pwm_readout i_angle_serial_pwm_readout (.mclk(mclk), .srst(srst), .clk_en(clk_en), .sclk(sclk),
    .chip_sel(chip_sel), .serial_data_pin_i(pin_level), .serial_data_pin_o(dev_o), .serial_data_pin_oe(dev_oe),
    .angle_sample(angle_sample), .sample_strobe(sample_strobe), .angle_invalid(angle_invalid),
    .agc_level(agc_level), .adc_lock(adc_lock), .store_supply_ok(store_supply_ok),
    .wake_threshold(wake_threshold), .gain_setting(gain_setting), .cosine_array_setup(cosine_array_setup),
    .sine_array_setup(sine_array_setup), .hysteresis_enable(hysteresis_enable), .sleep_request(sleep_request),
    .fuse_reload(fuse_reload), .turn_count(turn_count), .pwm_out(pwm_out));

  serial_master_model i_serial_master_model (.sclk(sclk), .chip_sel(chip_sel), .data_to_dev(pin_level),
    .dev_o(dev_o), .dev_oe(dev_oe));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (fuse_reload === 1'b1)
      fuse_n++;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic word_t mk(input word_t w);
    return {w[15:1], ^w[15:1]};
  endfunction

  task automatic chk(input string what, input word_t exp, input word_t got);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input string what, input cmd_t c, input word_t exp);
    i_serial_master_model.frame(c, 16'h0000, rx);
    chk(what, exp, rx);
  endtask

  task automatic wr(input cmd_t c, input word_t w);
    i_serial_master_model.frame(c, w, rx);
  endtask

  task automatic sample(input angle_t a);
    @(negedge mclk);
    angle_sample = a;
    sample_strobe = 1'b1;
    @(negedge mclk);
    sample_strobe = 1'b0;
  endtask

  task automatic cnt(input logic lvl, output int k);
    k = 0;
    while (pwm_out === lvl && k < 2000)
    begin
      @(negedge mclk);
      k++;
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset_values();
    chk("wake", 16'(`WAKE_RESET), 16'(wake_threshold));
    chk("arrays", 16'h0000, cosine_array_setup | sine_array_setup);
    chk("hyst sleep turns", 16'h0200, {6'h00, hysteresis_enable, sleep_request, turn_count});
    rd("cust read", `CMD_CUST_FETCH, mk(16'h0400));
  endtask

  task automatic test_settings();
    wr(`CMD_CUST_LOAD, 16'h1420);
    chk("wake gain", 16'h1401, {1'b0, wake_threshold, 5'h00, gain_setting});
    rd("cust read", `CMD_CUST_FETCH, mk(16'h1420));
    wr(`CMD_CUST_LOAD, 16'h0360);
    chk("low wake refused", 16'h1403, {1'b0, wake_threshold, 5'h00, gain_setting});
    wr(`CMD_CUST_LOAD, 16'h7f00);
    chk("max wake", 16'h007f, 16'(wake_threshold));
    rd("unused read", 5'h05, 16'h0000);
  endtask

  task automatic test_arrays();
    wr(`CMD_COSINE_LOAD, 16'ha5c3);
    chk("cos array", 16'ha5c3, cosine_array_setup);
    rd("cos read", `CMD_COSINE_FETCH, 16'ha5c3);
    wr(`CMD_SINE_LOAD, 16'h3c96);
    chk("sin array", 16'h3c96, sine_array_setup);
    rd("sin read", `CMD_SINE_FETCH, 16'h3c96);
  endtask

  task automatic test_measure_turns();
    sample(8'h5b);
    sample(8'h5b);
    rd("angle read", `CMD_ANGLE_FETCH, mk({1'b1, 6'h2a, 8'h5b, 1'b0}));
    rd("turn read", `CMD_TURNS_FETCH, mk({1'b1, 6'h2a, 8'h00, 1'b0}));
    sample(8'h60);
    rd("hyst hold", `CMD_BOTH_FETCH, 16'h005b);
    sample(8'h60);
    sample(8'hf0);
    sample(8'hf0);
    sample(8'h10);
    sample(8'h10);
    rd("both read", `CMD_BOTH_FETCH, 16'h0110);
    wr(`CMD_HYST_LOAD, 16'ha800);
    chk("clear fuse hyst", 16'h0101, {7'h00, hysteresis_enable, turn_count + 8'(fuse_n)});
    wr(`CMD_HYST_LOAD, 16'h0000);
    sample(8'h20);
    rd("no hyst", `CMD_BOTH_FETCH, 16'h0020);
    chk("hyst off", 16'h0001, {hysteresis_enable, 7'h00, 8'(fuse_n)});
  endtask

  task automatic test_store_sleep();
    rd("store first", `CMD_STORE_REF, 16'h0000);
    rd("store result", `CMD_STORE_REF, mk({1'b1, 6'h00, 8'h20, 1'b0}));
    @(negedge mclk);
    store_supply_ok = 1'b0;
    rd("store again", `CMD_STORE_REF, mk({1'b1, 6'h00, 8'h20, 1'b0}));
    rd("store bad supply", `CMD_STORE_REF, mk({1'b0, 6'h00, 8'h20, 1'b0}));
    wr(`CMD_SLEEP_LOAD, 16'h8000);
    chk("sleep on", 16'h0001, 16'(sleep_request));
    rd("lock in sleep", `CMD_ANGLE_FETCH, mk({1'b0, 6'h2a, 8'h20, 1'b0}));
    wr(`CMD_SLEEP_LOAD, 16'h0000);
    chk("sleep off", 16'h0000, 16'(sleep_request));
  endtask

  task automatic test_soft_reset();
    wr(`CMD_TEST_LOAD, 16'hbfff);
    chk("no reset", 16'h007f, 16'(wake_threshold));
    wr(`CMD_TEST_LOAD, 16'h4000);
    chk("reset wake", 16'(`WAKE_RESET), 16'(wake_threshold));
    chk("reset arrays", 16'h0000, cosine_array_setup);
    sample(8'hff);
    sample(8'hff);
  endtask

  task automatic test_pwm();
    angle_t a;
    for (int j = 0; j < 2; j++)
    begin
      a = j ? 8'hff : 8'h00;
      sample(a);
      sample(a);
      cnt(1'b1, n);
      cnt(1'b0, n);
      cnt(1'b1, hi);
      cnt(1'b0, lo);
      chk("pwm high", 16'((a + 1) * `PWM_LSB_CYC), 16'(hi));
      chk("pwm period", 16'(257 * `PWM_LSB_CYC), 16'(hi + lo));
    end
    @(negedge mclk);
    angle_invalid = 1'b1;
    repeat (3) @(negedge mclk);
    cnt(1'b0, n);
    chk("pwm held low", 16'd2000, 16'(n));
    angle_invalid = 1'b0;
  endtask

  initial
  begin
    mismatches = 0;
    n_compared = 0;
    fuse_n = 0;
    srst = 1'b1;
    clk_en = 1'b1;
    angle_sample = 8'h00;
    sample_strobe = 1'b0;
    angle_invalid = 1'b0;
    agc_level = 6'h2a;
    adc_lock = 1'b1;
    store_supply_ok = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    repeat (5) @(negedge mclk);
    test_reset_values();
    test_settings();
    test_arrays();
    test_measure_turns();
    test_store_sleep();
    test_soft_reset();
    test_pwm();
    end_of_test();
  end

  initial
  begin
    #3000000;
    mismatches++;
    end_of_test();
  end
endmodule
